// *** hdl/dcd_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RQ1] Each channel holds a 3-bit output range code, 0-5 V by default.
// [RQ2] Each channel's voltage overrange enable is cleared after reset.
// [RQ3] A word with top bits 100 is a software command with enable and code.
// [RQ4] Bit 12 of a software command sets or clears frame checking.
// [RQ5] Software command code 0x555 causes a full software reset.
// [RQ6] With the watchdog on, the host sends code 0x195 before each timeout.
// [RQ7] A missed keep-alive with the watchdog on raises the fault pin.
// [RQ8] A disabled watchdog needs no keep-alive and raises no fault.
// [RQ9] A word with top bits 011 is a boost control write; bits 12:7 ignored.
// [RQ10] Boost bits 6, 5:4, 3:2, 1:0 are comp, phase, rate and ceiling.
// [RQ11] Compensation select resets to 0, internal resistor.
// [RQ12] Phase select sets per-channel switching clock offsets.
// [RQ13] Rate select picks the divide of the 13 MHz oscillator.
// [RQ14] Ceiling select limits boost voltage, 23 V code by default.
// [RQ15] Software reset returns every field here to its reset default.
module dcd_decode
   import dcd_pkg::*;
(
   input  wire logic                     clk,          // 125 MHz clock
   input  wire logic                     rst_b,        // Async reset, low
   input  wire logic                     word_valid,   // Word strobe
   input  wire logic [15:0]              word_data,    // Decoded word
   input  wire logic                     chan_wr,      // Channel ctrl write
   input  wire logic [1:0]               chan_sel,     // Target channel
   input  wire logic                     wd_enable,    // Watchdog on
   input  wire logic [23:0]              wd_period,    // Timeout, cycles
   output logic [NUM_CHAN-1:0][2:0]      output_range_select,       // Range
   output logic [NUM_CHAN-1:0]           voltage_overrange_enable,  // Ovr
   output logic [NUM_CHAN-1:0]           range_is_current,          // mA
   output logic                          frame_check_enable,        // Check
   output logic                          converter_comp_select,     // Comp
   output logic [1:0]                    converter_phase_select,    // Phase
   output logic [NUM_CHAN-1:0][1:0]      converter_phase_quarter,   // Offs
   output logic [1:0]                    converter_switch_rate,     // Rate
   output logic [5:0]                    converter_switch_divide,   // Div
   output logic [1:0]                    converter_ceiling_voltage, // Max V
   output logic                          soft_reset_pulse,          // Reset
   output logic                          fault_alert                // Fault
);

   dcd_state_t st_reg;
   dcd_state_t st_next;
   dcd_wd_if   wd_bus ();

   logic [2:0]  word_class;
   logic [11:0] word_code;
   logic        is_softcmd;
   logic        is_boost;
   logic        is_reset;
   logic [1:0]  new_rate;
   logic [1:0]  new_phase;

   assign word_class = word_data[CLASS_MSB:CLASS_LSB];
   assign word_code  = word_data[SC_CODE_MSB:0];
   assign is_softcmd = word_valid && !chan_wr
                       && (word_class == CLASS_SOFTCMD); // [RQ3]
   assign is_boost   = word_valid && !chan_wr
                       && (word_class == CLASS_BOOST); // [RQ9]
   assign is_reset   = is_softcmd && (word_code == SC_CODE_RESET); // [RQ5]
   assign new_phase  = word_data[BC_PHASE_LSB+:2]; // [RQ10]
   assign new_rate   = word_data[BC_RATE_LSB+:2]; // [RQ10]

   always_comb begin
      st_next        = st_reg;
      st_next.sreset = 1'b0;
      if (is_reset) begin
         // Same values as power-on; the reset word's own check bit is dropped
         st_next.range   = {NUM_CHAN{RST_RANGE}}; // [RQ15]
         st_next.ovr     = {NUM_CHAN{RST_OVR}}; // [RQ15]
         st_next.fce     = RST_FCE; // [RQ15]
         st_next.comp    = RST_COMP; // [RQ15]
         st_next.phase   = RST_PHASE; // [RQ15]
         st_next.rate    = RST_RATE; // [RQ15]
         st_next.ceil    = RST_CEIL; // [RQ15]
         st_next.div     = RST_DIV; // [RQ15]
         st_next.quarter = '0; // [RQ15]
         st_next.sreset  = 1'b1; // [RQ5]
      end else if (is_softcmd) begin
         st_next.fce = word_data[SC_FCE_BIT]; // [RQ4]
      end else if (is_boost) begin
         // Bits 12:7 are never looked at
         st_next.comp  = word_data[BC_COMP_BIT]; // [RQ11]
         st_next.ceil  = word_data[BC_CEIL_LSB+:2]; // [RQ14]
         st_next.phase = new_phase; // [RQ12]
         unique case (new_phase)
            PH_SAME: begin
               st_next.quarter = '0; // [RQ12]
            end
            PH_AB_CD: begin
               st_next.quarter = {QTR_180, QTR_180, QTR_0, QTR_0}; // [RQ12]
            end
            PH_AC_BD: begin
               st_next.quarter = {QTR_180, QTR_0, QTR_180, QTR_0}; // [RQ12]
            end
            PH_QUAD: begin
               st_next.quarter = {2'h3, 2'h2, 2'h1, 2'h0}; // [RQ12]
            end
         endcase
         // Rate code 11 is unassigned; the previous rate is kept
         unique case (new_rate)
            RATE_250K: begin
               st_next.rate = new_rate; // [RQ13]
               st_next.div  = DIV_250K; // [RQ13]
            end
            RATE_410K: begin
               st_next.rate = new_rate; // [RQ13]
               st_next.div  = DIV_410K; // [RQ13]
            end
            RATE_650K: begin
               st_next.rate = new_rate; // [RQ13]
               st_next.div  = DIV_650K; // [RQ13]
            end
            default: begin
               st_next.rate = st_reg.rate;
            end
         endcase
      end else if (word_valid && chan_wr) begin
         // Code 111 has no range; the write leaves the range untouched
         if (word_data[CH_RANGE_LSB+:3] != RANGE_ILLEGAL) begin
            st_next.range[chan_sel] = word_data[CH_RANGE_LSB+:3]; // [RQ1]
         end
         st_next.ovr[chan_sel] = word_data[CH_OVR_BIT]; // [RQ2]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg.range   <= {NUM_CHAN{RST_RANGE}}; // [RQ1]
         st_reg.ovr     <= {NUM_CHAN{RST_OVR}}; // [RQ2]
         st_reg.fce     <= RST_FCE;
         st_reg.comp    <= RST_COMP; // [RQ11]
         st_reg.phase   <= RST_PHASE; // [RQ12]
         st_reg.rate    <= RST_RATE; // [RQ13]
         st_reg.ceil    <= RST_CEIL; // [RQ14]
         st_reg.div     <= RST_DIV;
         st_reg.quarter <= '0;
         st_reg.sreset  <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Keep-alive is the host's duty; a kick restarts the count and clears the fault
   assign wd_bus.enable = wd_enable; // [RQ8]
   assign wd_bus.period = wd_period;
   assign wd_bus.kick   = is_softcmd
                          && (word_code == SC_CODE_KICK); // [RQ6]
   assign wd_bus.clear  = st_reg.sreset;

   dcd_watchdog u_watchdog (
      .clk   (clk),
      .rst_b (rst_b),
      .wd    (wd_bus.timer)
   );

   assign output_range_select       = st_reg.range;
   assign voltage_overrange_enable  = st_reg.ovr;
   assign frame_check_enable        = st_reg.fce;
   assign converter_comp_select     = st_reg.comp;
   assign converter_phase_select    = st_reg.phase;
   assign converter_phase_quarter   = st_reg.quarter;
   assign converter_switch_rate     = st_reg.rate;
   assign converter_switch_divide   = st_reg.div;
   assign converter_ceiling_voltage = st_reg.ceil;
   assign soft_reset_pulse          = st_reg.sreset;
   assign fault_alert               = wd_bus.fault; // [RQ7]

   generate
      for (genvar c = 0; c < NUM_CHAN; c++) begin : g_cur
         assign range_is_current[c] = st_reg.range[c][2]; // [RQ1]
      end
   endgenerate

endmodule
`default_nettype wire

// *** hdl/dcd_pkg.sv ***
package dcd_pkg;

   localparam int unsigned CLK_FREQ_HZ = 125000000;

   // Word class in bits 15:13
   localparam int unsigned       CLASS_MSB     = 15;
   localparam int unsigned       CLASS_LSB     = 13;
   localparam logic [2:0]        CLASS_SOFTCMD = 3'h4;
   localparam logic [2:0]        CLASS_BOOST   = 3'h3;

   // Software command word fields
   localparam int unsigned       SC_FCE_BIT    = 12;
   localparam int unsigned       SC_CODE_MSB   = 11;
   localparam logic [11:0]       SC_CODE_RESET = 12'h555;
   localparam logic [11:0]       SC_CODE_KICK  = 12'h195;

   // Boost converter control fields; bits 12:7 are don't care
   localparam int unsigned       BC_COMP_BIT   = 6;
   localparam int unsigned       BC_PHASE_LSB  = 4;
   localparam int unsigned       BC_RATE_LSB   = 2;
   localparam int unsigned       BC_CEIL_LSB   = 0;

   // Channel control write fields
   localparam int unsigned       CH_RANGE_LSB  = 0;
   localparam int unsigned       CH_OVR_BIT    = 3;
   localparam int unsigned       NUM_CHAN      = 4;

   // Output range codes
   localparam logic [2:0] RANGE_V0_5    = 3'h0;
   localparam logic [2:0] RANGE_V0_10   = 3'h1;
   localparam logic [2:0] RANGE_VPM5    = 3'h2;
   localparam logic [2:0] RANGE_VPM10   = 3'h3;
   localparam logic [2:0] RANGE_I4_20   = 3'h4;
   localparam logic [2:0] RANGE_I0_20   = 3'h5;
   localparam logic [2:0] RANGE_I0_24   = 3'h6;
   localparam logic [2:0] RANGE_ILLEGAL = 3'h7;

   // Switching rate codes and divide ratios from the 13 MHz oscillator
   localparam int unsigned OSC_KHZ      = 13000;
   localparam logic [1:0]  RATE_250K    = 2'h0;
   localparam logic [1:0]  RATE_410K    = 2'h1;
   localparam logic [1:0]  RATE_650K    = 2'h2;
   localparam logic [5:0]  DIV_250K     = 6'(OSC_KHZ / 250);
   localparam logic [5:0]  DIV_410K     = 6'((OSC_KHZ + 205) / 410);
   localparam logic [5:0]  DIV_650K     = 6'(OSC_KHZ / 650);

   // Phase select codes; quarter offsets 0..3 = 0/90/180/270 deg
   localparam logic [1:0]  PH_SAME      = 2'h0;
   localparam logic [1:0]  PH_AB_CD     = 2'h1;
   localparam logic [1:0]  PH_AC_BD     = 2'h2;
   localparam logic [1:0]  PH_QUAD      = 2'h3;
   localparam logic [1:0]  QTR_0        = 2'h0;
   localparam logic [1:0]  QTR_180      = 2'h2;

   // Values after reset
   localparam logic [2:0]  RST_RANGE    = RANGE_V0_5;
   localparam logic        RST_OVR      = 1'b0;
   localparam logic        RST_FCE      = 1'b0;
   localparam logic        RST_COMP     = 1'b0;
   localparam logic [1:0]  RST_PHASE    = PH_SAME;
   localparam logic [1:0]  RST_RATE     = RATE_410K;
   localparam logic [1:0]  RST_CEIL     = 2'h0;
   localparam logic [5:0]  RST_DIV      = DIV_410K;

   localparam int unsigned WD_CNT_W     = 24;

   typedef struct packed {
      logic [NUM_CHAN-1:0][2:0] range;
      logic [NUM_CHAN-1:0]      ovr;
      logic                     fce;
      logic                     comp;
      logic [1:0]               phase;
      logic [1:0]               rate;
      logic [1:0]               ceil;
      logic [5:0]               div;
      logic [NUM_CHAN-1:0][1:0] quarter;
      logic                     sreset;
   } dcd_state_t;

   typedef struct packed {
      logic [WD_CNT_W-1:0] count;
      logic                fault;
   } dcd_wd_state_t;

endpackage

// *** hdl/dcd_watchdog.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcd_watchdog
   import dcd_pkg::*;
(
   input  wire logic clk,      // System clock
   input  wire logic rst_b,    // Async reset, active low
   dcd_wd_if.timer   wd        // Control from the decoder
);

   dcd_wd_state_t st_reg;
   dcd_wd_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!wd.enable || wd.clear) begin
         // Disabled timer never faults and needs no keep-alive
         st_next.count = '0; // [RQ8]
         st_next.fault = 1'b0; // [RQ8]
      end else if (wd.kick) begin
         st_next.count = '0;
         st_next.fault = 1'b0;
      end else if (st_reg.count >= wd.period - 24'h1) begin
         // Count holds at the limit so fault stays until a kick, a software reset or the watchdog is disabled
         st_next.fault = 1'b1; // [RQ7]
      end else begin
         st_next.count = st_reg.count + 24'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wd.fault = st_reg.fault;

endmodule
`default_nettype wire

// *** hdl/dcd_wd_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface dcd_wd_if;
   logic        enable;
   logic [23:0] period;
   logic        kick;
   logic        clear;
   logic        fault;

   modport ctrl  (output enable, output period, output kick,
                  output clear, input fault);
   modport timer (input enable, input period, input kick,
                  input clear, output fault);
endinterface
`default_nettype wire

// *** tb/dac_config_command_decode_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dac_config_command_decode_tb_top import dcd_pkg::*;;
   logic                     clk = 1'b0, rst_b = 1'b0, wd_enable = 1'b0;
   logic [23:0]              wd_period = 24'h8;
   logic                     word_valid, chan_wr, fce, comp, pulse, fault;
   logic [15:0]              word_data;
   logic [1:0]               chan_sel, ph, rate, ceil;
   logic [NUM_CHAN-1:0][2:0] rng;
   logic [NUM_CHAN-1:0]      ovr, cur;
   logic [NUM_CHAN-1:0][1:0] qtr;
   logic [5:0]               div;
   logic [31:0]              seed = 32'h8394;
   int error_cnt = 0, tests_run = 0;
   int m_rng[4], m_ovr[4], m_fce, m_comp, m_ph, m_rate, m_ceil;
   always #4 clk = ~clk;
   dcd_host_model i_host (.clk(clk), .word_valid(word_valid),
      .word_data(word_data), .chan_wr(chan_wr), .chan_sel(chan_sel));
   dcd_decode i_dut (.clk(clk), .rst_b(rst_b), .word_valid(word_valid),
      .word_data(word_data), .chan_wr(chan_wr), .chan_sel(chan_sel),
      .wd_enable(wd_enable), .wd_period(wd_period),
      .output_range_select(rng), .voltage_overrange_enable(ovr),
      .range_is_current(cur), .frame_check_enable(fce),
      .converter_comp_select(comp), .converter_phase_select(ph),
      .converter_phase_quarter(qtr), .converter_switch_rate(rate),
      .converter_switch_divide(div), .converter_ceiling_voltage(ceil),
      .soft_reset_pulse(pulse), .fault_alert(fault));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic void mreset();
      foreach (m_rng[c]) m_rng[c] = 0;
      foreach (m_ovr[c]) m_ovr[c] = 0;
      m_fce = 0;
      m_comp = 0;
      m_ph = 0;
      m_rate = 1;
      m_ceil = 0;
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk_cfg(input logic [41:0] got, input logic [41:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: config %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic check_model();
      logic [41:0] e;
      int d;
      d = m_rate == 0 ? 52 : m_rate == 1 ? 32 : 20;
      for (int c = 0; c < 4; c++) begin
         e[30+3*c +: 3] = m_rng[c][2:0];
         e[26+c] = m_ovr[c][0];
         e[22+c] = m_rng[c] >= 4;
         e[14+2*c +: 2] = 2'(m_ph == 0 ? 0 : m_ph == 1 ? (c / 2) * 2 :
                             m_ph == 2 ? (c % 2) * 2 : c);
      end
      e[13:0] = {m_fce[0], m_comp[0], m_ph[1:0], m_rate[1:0], m_ceil[1:0],
                 d[5:0]};
      chk_cfg({rng, ovr, cur, qtr, fce, comp, ph, rate, ceil, div}, e);
   endtask
   task automatic put(input logic [15:0] w, input logic cw,
                      input logic [1:0] s);
      i_host.send(w, cw, s);
      if (cw) begin
         if (w[2:0] != 3'h7) m_rng[s] = w[2:0];
         m_ovr[s] = w[3];
      end else if (w[15:13] == 3'h3) begin
         m_comp = w[6];
         m_ph = w[5:4];
         m_ceil = w[1:0];
         if (w[3:2] != 2'h3) m_rate = w[3:2];
      end else if (w[15:13] == 3'h4 && w[11:0] == 12'h555) mreset();
      else if (w[15:13] == 3'h4) m_fce = w[12];
      chk_flag(pulse, !cw && w[15:13] == 3'h4 && w[11:0] == 12'h555);
      check_model();
   endtask
   // Bounded wait; running out is a mismatch and ends the run
   task automatic wait_fault(output int n);
      n = 0;
      while (fault !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 20) begin
         error_cnt++;
         $display("Error at %0t: no fault seen", $time);
         close_out();
      end
   endtask
   initial begin
      logic [31:0] r;
      int n;
      mreset();
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      check_model();
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 8; k++) begin
            r = rnd();
            put({r[15:3], 3'(k)}, 1'b1, 2'(c));
         end
      end
      $display("test channel ranges done");
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         put({3'h3, r[12:6], 4'(i), r[1:0]}, 1'b0, r[1:0]);
      end
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         if (k != 3 && k != 4) put({3'(k), r[12:0]}, 1'b0, r[1:0]);
      end
      $display("test boost and classes done");
      put(16'h9000, 1'b0, 2'h0);
      put(16'h8abc, 1'b0, 2'h1);
      put(16'h9abc, 1'b0, 2'h2);
      put(16'h9555, 1'b0, 2'h3);
      $display("test software commands done");
      wd_enable = 1'b1;
      repeat (4) begin
         put(16'h8195, 1'b0, 2'h0);
         chk_flag(fault, 1'b0);
      end
      // Fault lands a full timeout after the kick edge
      wait_fault(n);
      chk_flag(n == wd_period, 1'b1);
      put(16'h9555, 1'b0, 2'h0);
      @(posedge clk);
      #1;
      chk_flag(fault, 1'b0);
      wait_fault(n);
      chk_flag(n == wd_period, 1'b1);
      wd_enable = 1'b0;
      repeat (20) begin
         @(posedge clk);
         #1;
         chk_flag(fault, 1'b0);
      end
      $display("test watchdog done");
      close_out();
   end
endmodule
`default_nettype wire

// *** tb/dcd_decode_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcd_decode_properties
   import dcd_pkg::*;
(
   input wire logic                     clk,   // Clock
   input wire logic                     rst_b, // Reset
   input wire logic                     word_valid, // Strobe
   input wire logic [15:0]              word_data,  // Word
   input wire logic                     chan_wr,    // Chan write
   input wire logic [1:0]               chan_sel,   // Chan
   input wire logic                     wd_enable,  // Wd on
   input wire logic [23:0]              wd_period,  // Timeout
   input wire logic [NUM_CHAN-1:0][2:0] output_range_select, // Range
   input wire logic [NUM_CHAN-1:0]      voltage_overrange_enable, // Ovr
   input wire logic [NUM_CHAN-1:0]      range_is_current, // mA
   input wire logic                     frame_check_enable, // Check
   input wire logic                     converter_comp_select, // Comp
   input wire logic [1:0]               converter_phase_select, // Phase
   input wire logic [NUM_CHAN-1:0][1:0] converter_phase_quarter, // Offs
   input wire logic [1:0]               converter_switch_rate, // Rate
   input wire logic [5:0]               converter_switch_divide, // Div
   input wire logic [1:0]               converter_ceiling_voltage, // Max
   input wire logic                     soft_reset_pulse, // Pulse
   input wire logic                     fault_alert // Fault
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic       soft_w;
   logic       boost_w;
   logic       reset_w;
   logic       kick_w;
   logic [7:0] quarter_exp;
   assign soft_w = word_valid && !chan_wr && word_data[15:13] == 3'h4;
   assign boost_w = word_valid && !chan_wr && word_data[15:13] == 3'h3;
   assign reset_w = soft_w && word_data[11:0] == 12'h555;
   assign kick_w = soft_w && word_data[11:0] == 12'h195;
   // Offsets per channel, D in the top pair, A in the bottom pair
   always_comb begin
      unique case (converter_phase_select)
         2'h0: quarter_exp = 8'h00;
         2'h1: quarter_exp = 8'ha0;
         2'h2: quarter_exp = 8'h88;
         2'h3: quarter_exp = 8'he4;
      endcase
   end
   // Back to back reset words legally stretch the pulse
   a_pulse_single: assert property (
      soft_reset_pulse |=> !soft_reset_pulse || $past(reset_w))
      else $error("reset pulse too long");
   a_reset_word: assert property (
      reset_w |=> soft_reset_pulse)
      else $error("reset word gave no pulse");
   a_sreset_defaults: assert property (soft_reset_pulse |->
      output_range_select == '0 && voltage_overrange_enable == '0 &&
      !frame_check_enable && !converter_comp_select &&
      converter_phase_select == 2'h0 && converter_phase_quarter == '0 &&
      converter_switch_rate == 2'h1 &&
      converter_ceiling_voltage == 2'h0 && converter_switch_divide == 6'h20)
      else $error("fields not default after software reset");
   a_check_bit: assert property (
      soft_w && !reset_w |=> frame_check_enable == $past(word_data[12]))
      else $error("frame check bit not taken");
   a_boost_fields: assert property (boost_w |=>
      converter_comp_select == $past(word_data[6]) &&
      converter_phase_select == $past(word_data[5:4]) &&
      converter_ceiling_voltage == $past(word_data[1:0]))
      else $error("boost fields wrong");
   a_rate_divide: assert property (converter_switch_divide ==
      (converter_switch_rate == 2'h0 ? 6'h34 :
       converter_switch_rate == 2'h1 ? 6'h20 : 6'h14))
      else $error("divide does not match rate");
   a_range_write: assert property (
      word_valid && chan_wr && word_data[2:0] != 3'h7
      |=> output_range_select[$past(chan_sel)] == $past(word_data[2:0]) &&
      voltage_overrange_enable[$past(chan_sel)] == $past(word_data[3]))
      else $error("channel write not taken");
   a_wd_off: assert property (!wd_enable |=> !fault_alert)
      else $error("fault while watchdog off");
   a_fault_cause: assert property (
      $rose(fault_alert) |-> $past(wd_enable))
      else $error("fault without watchdog");
   a_kick_clears: assert property (
      wd_enable && kick_w |=> !fault_alert)
      else $error("fault stands after keep-alive");
   a_quarter_match: assert property (
      converter_phase_quarter == quarter_exp)
      else $error("phase offsets do not match phase select");
endmodule
bind dcd_decode dcd_decode_properties u_props (.clk(clk), .rst_b(rst_b),
   .word_valid(word_valid), .word_data(word_data), .chan_wr(chan_wr),
   .chan_sel(chan_sel), .wd_enable(wd_enable), .wd_period(wd_period),
   .output_range_select(output_range_select),
   .voltage_overrange_enable(voltage_overrange_enable),
   .range_is_current(range_is_current),
   .frame_check_enable(frame_check_enable),
   .converter_comp_select(converter_comp_select),
   .converter_phase_select(converter_phase_select),
   .converter_phase_quarter(converter_phase_quarter),
   .converter_switch_rate(converter_switch_rate),
   .converter_switch_divide(converter_switch_divide),
   .converter_ceiling_voltage(converter_ceiling_voltage),
   .soft_reset_pulse(soft_reset_pulse), .fault_alert(fault_alert));
`default_nettype wire

// *** tb/dcd_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcd_host_model (
   input  wire logic        clk,        // System clock
   output var  logic        word_valid, // Word strobe
   output var  logic [15:0] word_data,  // Word
   output var  logic        chan_wr,    // Channel write
   output var  logic [1:0]  chan_sel    // Channel
);
   initial begin
      word_valid = 1'b0;
      word_data = 16'h0;
      chan_wr = 1'b0;
      chan_sel = 2'h0;
   end
   // Lines left inverted after a word so a stale value is never read
   task automatic send(input logic [15:0] w, input logic cw,
                       input logic [1:0] s);
      @(posedge clk);
      #1;
      word_valid = 1'b1;
      word_data = w;
      chan_wr = cw;
      chan_sel = s;
      @(posedge clk);
      #1;
      word_valid = 1'b0;
      word_data = ~w;
      chan_wr = ~cw;
      chan_sel = ~s;
   endtask
endmodule
`default_nettype wire
